/* tsr_cfg.svh */
// Offsets, field positions, reset values and tag codes of the target sector block
`ifndef TSR_CFG_SVH
`define TSR_CFG_SVH

`define TSR_TAG_TARGET   3'h5
`define TSR_TAG_CONTROL  3'h7

`define TSR_OFF_STATUS   12'h000
`define TSR_OFF_MASK     12'h004
`define TSR_OFF_CTRL     12'h008
`define TSR_OFF_STATE    12'h00C

`define TSR_EV_MATCH     0
`define TSR_EV_TARGET    1
`define TSR_EV_CONTROL   2
`define TSR_EV_W         3

`define TSR_CTRL_ENABLE  0
`define TSR_CTRL_DISARM  1

`define TSR_ARM_BIT      0

`define TSR_MASK_RST     3'h0
`define TSR_STATUS_RST   3'h0
`define TSR_ENABLE_RST   1'h1
`define TSR_SECTOR_RST   7'h00

`define TSR_SECTOR_W     7

`endif

/* tsr_ctrl_model.sv */
// Drive controller model: issues tags and spins sector and index marks
`timescale 1ns/1ps
module tsr_ctrl_model (
  input  wire logic       sys_clk,
  output logic            tag_gate,
  output logic [2:0]      tag_code,
  output logic [7:0]      outbound_bus_bit,
  output logic            sector_mark,
  output logic            index_mark
);
  initial begin
    tag_gate = 1'b0;
    tag_code = 3'h0;
    outbound_bus_bit = 8'hA5;
    sector_mark = 1'b0;
    index_mark = 1'b0;
  end

  // Gate held for hold cycles; one rising edge is one command
  task automatic send_tag(input logic [2:0] code, input logic [7:0] ob, input int hold);
    @(posedge sys_clk);
    tag_gate <= 1'b1;
    tag_code <= code;
    outbound_bus_bit <= ob;
    repeat (hold) @(posedge sys_clk);
    tag_gate <= 1'b0;
    // Released bus must not keep looking valid
    outbound_bus_bit <= ~ob;
    tag_code <= ~code;
    @(posedge sys_clk);
  endtask : send_tag

  task automatic mark(input logic idx);
    @(posedge sys_clk);
    sector_mark <= ~idx;
    index_mark <= idx;
    @(posedge sys_clk);
    sector_mark <= 1'b0;
    index_mark <= 1'b0;
  endtask : mark
endmodule : tsr_ctrl_model

/* tsr_pkg.sv */
// Types shared by the target sector block
package tsr_pkg;

  typedef logic [6:0] tsr_sector_t;

  typedef enum logic [1:0] {
    TSR_APB_IDLE = 2'b01,
    TSR_APB_ACK  = 2'b10
  } tsr_apb_e;

  typedef struct packed {
    tsr_sector_t count;
  } tsr_cnt_s;

  typedef struct packed {
    tsr_apb_e    apb;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        tag_gate_prev;
    logic        armed;
    tsr_sector_t target;
    logic [7:0]  inbound;
    logic        rps_int;
    logic [2:0]  status;
    logic [2:0]  mask;
    logic        enable;
    logic        irq;
  } tsr_top_s;

endpackage : tsr_pkg

/* tsr_sector_cnt.sv */
// Present sector counter, advanced by sector marks and cleared by the index mark
`timescale 1ns/1ps
`include "tsr_cfg.svh"

module tsr_sector_cnt
  import tsr_pkg::*;
#(
  parameter int SECTOR_W = `TSR_SECTOR_W
) (
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  input  wire logic                sector_mark,
  input  wire logic                index_mark,
  output logic [SECTOR_W-1:0]      count_q
);

  if (SECTOR_W != `TSR_SECTOR_W) begin : g_bad_width
    $error("tsr_sector_cnt: sector width must match the 7-bit bus field");
  end

  tsr_cnt_s s_q;
  tsr_cnt_s s_d;

  always_comb begin
    s_d = s_q;
    if (index_mark) begin
      s_d.count = `TSR_SECTOR_RST;
    end else if (sector_mark) begin
      s_d.count = s_q.count + 7'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q.count <= `TSR_SECTOR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign count_q = s_q.count;

  index_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    index_mark |=> (count_q == 7'h00))
    else $error("sector count not cleared by index mark");

  sector_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (sector_mark && !index_mark) |=> (count_q == 7'($past(count_q) + 7'h01)))
    else $error("sector count did not advance on sector mark");

endmodule : tsr_sector_cnt

/* tsr_top.sv */
// Target register command, rotational sector sensing and APB status for the drive
// What this block does
// - Tag 101 arms sensing or reports present sector
// - Arm bit set loads target from bits 1-7
// - Armed: interrupt at every pass of target
// - Arm bit clear loads target with present sector
// - Arm bit clear leaves sensing disarmed
// - Sector bits: bit 1 weight 64, bit 7 weight 1
// - Armed command echoes outbound byte inbound
// - Capture command returns sector at command time
// - Inbound bit 0 is select, bits 1-7 sector
// - Inbound byte shows the target register bits
// - Control tag bit 0 arms, copies present sector
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "tsr_cfg.svh"

module tsr_top
  import tsr_pkg::*;
#(
  parameter int SECTOR_W = `TSR_SECTOR_W
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        tag_gate,
  input  wire logic [2:0]  tag_code,
  input  wire logic [7:0]  outbound_bus_bit,
  input  wire logic        sector_mark,
  input  wire logic        index_mark,
  output logic      [7:0]  inbound_bus_bit,
  output logic             rps_int,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  output logic             irq
);

  if (SECTOR_W != `TSR_SECTOR_W) begin : g_bad_width
    $error("tsr_top: sector width must match the 7-bit bus field");
  end

  // Bus bit 1 is the heaviest sector bit, so the field is reversed
  function automatic tsr_sector_t sector_from_bus(input logic [7:0] b);
    tsr_sector_t s;
    s = '0;
    for (int i = 0; i < 7; i++) begin
      s[6-i] = b[i+1];
    end
    return s;
  endfunction : sector_from_bus

  function automatic logic [7:0] bus_from_sector(input tsr_sector_t s, input logic arm);
    logic [7:0] b;
    b = '0;
    b[`TSR_ARM_BIT] = arm;
    for (int i = 0; i < 7; i++) begin
      b[i+1] = s[6-i];
    end
    return b;
  endfunction : bus_from_sector

  function automatic logic addr_mapped(input logic [11:0] a);
    return (a == `TSR_OFF_STATUS) || (a == `TSR_OFF_MASK) ||
           (a == `TSR_OFF_CTRL) || (a == `TSR_OFF_STATE);
  endfunction : addr_mapped

  tsr_top_s    s_q;
  tsr_top_s    s_d;
  tsr_sector_t present_sec;
  tsr_sector_t bob_sector;
  logic        tag_rise;
  logic        tgt_cmd;
  logic        ctl_cmd;
  logic        match;
  logic        wr_en;
  logic [2:0]  ev;
  logic [2:0]  clr;
  logic [31:0] rd_val;

  tsr_sector_cnt #(
    .SECTOR_W    (SECTOR_W)
  ) u_cnt (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .sector_mark (sector_mark),
    .index_mark  (index_mark),
    .count_q     (present_sec)
  );

  assign bob_sector = sector_from_bus(outbound_bus_bit);
  // Tag is taken once, on the gate's rising edge, so a long gate is one command
  assign tag_rise   = tag_gate && !s_q.tag_gate_prev;
  assign tgt_cmd    = tag_rise && s_q.enable && (tag_code == `TSR_TAG_TARGET);
  assign ctl_cmd    = tag_rise && s_q.enable && (tag_code == `TSR_TAG_CONTROL) &&
                      outbound_bus_bit[`TSR_ARM_BIT];
  assign match      = s_q.armed && (present_sec == s_q.target);

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (paddr)
      `TSR_OFF_STATUS: rd_val[2:0] = s_q.status;
      `TSR_OFF_MASK:   rd_val[2:0] = s_q.mask;
      `TSR_OFF_CTRL:   rd_val[`TSR_CTRL_ENABLE] = s_q.enable;
      `TSR_OFF_STATE:  rd_val = {14'h0000, s_q.rps_int, s_q.armed, 1'b0, s_q.target, 1'b0, present_sec};
      default:         rd_val = 32'h0000_0000;
    endcase
  end

  always_comb begin
    s_d = s_q;
    wr_en = 1'b0;
    clr = 3'h0;
    s_d.tag_gate_prev = tag_gate;

    // One wait state: answer comes in the second access cycle
    unique case (s_q.apb)
      TSR_APB_IDLE: begin
        if (psel && penable) begin
          s_d.pready  = 1'b1;
          s_d.prdata  = rd_val;
          s_d.pslverr = !addr_mapped(paddr);
          s_d.apb     = TSR_APB_ACK;
        end
      end
      TSR_APB_ACK: begin
        wr_en       = psel && penable && pwrite && !s_q.pslverr;
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.apb     = TSR_APB_IDLE;
      end
    endcase

    if (wr_en) begin
      unique case (paddr)
        `TSR_OFF_STATUS: clr = pwdata[2:0];
        `TSR_OFF_MASK:   s_d.mask = pwdata[2:0];
        `TSR_OFF_CTRL: begin
          s_d.enable = pwdata[`TSR_CTRL_ENABLE];
          if (pwdata[`TSR_CTRL_DISARM]) begin
            s_d.armed = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Tag commands win over a software disarm in the same cycle
    if (tgt_cmd) begin
      if (outbound_bus_bit[`TSR_ARM_BIT]) begin
        s_d.target = bob_sector;
        s_d.armed  = 1'b1;
      end else begin
        s_d.target = present_sec;
        s_d.armed  = 1'b0;
      end
    end else if (ctl_cmd) begin
      s_d.target = present_sec;
      s_d.armed  = 1'b1;
    end

    s_d.inbound = bus_from_sector(s_d.target, s_d.armed);

    // Level for the whole matching sector; drops when the counter moves on
    s_d.rps_int = match;

    ev = 3'h0;
    ev[`TSR_EV_MATCH]   = match && !s_q.rps_int;
    ev[`TSR_EV_TARGET]  = tgt_cmd;
    ev[`TSR_EV_CONTROL] = ctl_cmd;
    // A new event beats a clear in the same cycle
    s_d.status = (s_q.status & ~clr) | ev;
    s_d.irq    = |(s_d.status & s_d.mask);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q.apb           <= TSR_APB_IDLE;
      s_q.pready        <= 1'b0;
      s_q.prdata        <= 32'h0000_0000;
      s_q.pslverr       <= 1'b0;
      s_q.tag_gate_prev <= 1'b0;
      s_q.armed         <= 1'b0;
      s_q.target        <= `TSR_SECTOR_RST;
      s_q.inbound       <= 8'h00;
      s_q.rps_int       <= 1'b0;
      s_q.status        <= `TSR_STATUS_RST;
      s_q.mask          <= `TSR_MASK_RST;
      s_q.enable        <= `TSR_ENABLE_RST;
      s_q.irq           <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign inbound_bus_bit = s_q.inbound;
  assign rps_int         = s_q.rps_int;
  assign pready          = s_q.pready;
  assign prdata          = s_q.prdata;
  assign pslverr         = s_q.pslverr;
  assign irq             = s_q.irq;

  tag_select_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tag_rise && s_q.enable && (tag_code == 3'h5)) |=> (s_q.armed == $past(outbound_bus_bit[0])))
    else $error("target tag did not follow the arm bit");

  arm_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tgt_cmd && outbound_bus_bit[0]) |=> (s_q.armed && (s_q.target == $past(bob_sector))))
    else $error("armed target command did not load target");

  capture_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tgt_cmd && !outbound_bus_bit[0]) |=> (s_q.target == $past(present_sec)))
    else $error("capture did not store present sector");

  capture_disarm_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tgt_cmd && !outbound_bus_bit[0]) |=> !s_q.armed ##1 !rps_int)
    else $error("capture command left sensing armed");

  sector_bits_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tgt_cmd && (outbound_bus_bit == 8'h81)) |=> (s_q.target == 7'h01))
    else $error("bus bit 7 is not the least significant sector bit");

  match_int_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (s_q.armed && (present_sec == s_q.target)) |=> rps_int)
    else $error("interrupt missing at target sector");

  match_release_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !(s_q.armed && (present_sec == s_q.target)) |=> !rps_int)
    else $error("interrupt held outside matching sector");

  echo_out_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tgt_cmd && outbound_bus_bit[0]) |=> (inbound_bus_bit == $past(outbound_bus_bit)))
    else $error("inbound byte is not an echo of outbound byte");

  present_echo_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tgt_cmd && !outbound_bus_bit[0]) |=>
      (!inbound_bus_bit[0] && (sector_from_bus(inbound_bus_bit) == $past(present_sec))))
    else $error("inbound byte does not show captured sector");

  inbound_map_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (inbound_bus_bit[0] == s_q.armed) && (sector_from_bus(inbound_bus_bit) == s_q.target))
    else $error("inbound byte differs from target register");

  control_arm_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ctl_cmd |=> (s_q.armed && (s_q.target == $past(present_sec))))
    else $error("control tag did not arm and copy sector");

  irq_level_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    irq == |(s_q.status & s_q.mask))
    else $error("interrupt output disagrees with status and mask");

  apb_wait_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("APB answer not given after one wait state");

  target_event_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    tgt_cmd |=> s_q.status[`TSR_EV_TARGET])
    else $error("target tag did not set its status bit");

  control_event_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ctl_cmd |=> s_q.status[`TSR_EV_CONTROL])
    else $error("control tag did not set its status bit");

  match_event_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (match && !rps_int) |=> s_q.status[`TSR_EV_MATCH])
    else $error("match start did not set its status bit");

  status_sticky_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    1'b1 |=> ((($past(s_q.status) & ~$past(clr)) & ~s_q.status) == 3'h0))
    else $error("status bit lost without a clear");

  status_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clr[`TSR_EV_MATCH] && !ev[`TSR_EV_MATCH]) |=> !s_q.status[`TSR_EV_MATCH])
    else $error("write of one did not clear match status");

  gate_held_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tag_gate && s_q.tag_gate_prev) |=> (s_q.target == $past(s_q.target)))
    else $error("held tag gate was taken as a new command");

  tag_disabled_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tag_rise && !s_q.enable) |=> (s_q.target == $past(s_q.target)))
    else $error("tag taken while tag handling disabled");

  other_code_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tag_rise && (tag_code != `TSR_TAG_TARGET) && (tag_code != `TSR_TAG_CONTROL)) |=>
      ((s_q.target == $past(s_q.target)) && (!s_q.armed || $past(s_q.armed))))
    else $error("foreign tag code changed the target register");

  control_ignore_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tag_rise && (tag_code == `TSR_TAG_CONTROL) && !outbound_bus_bit[`TSR_ARM_BIT]) |=>
      (s_q.target == $past(s_q.target)))
    else $error("control tag without transfer bit changed target");

  disarm_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (wr_en && (paddr == `TSR_OFF_CTRL) && pwdata[`TSR_CTRL_DISARM] && !tgt_cmd && !ctl_cmd) |=>
      (!s_q.armed && !inbound_bus_bit[`TSR_ARM_BIT]))
    else $error("software disarm not applied");

  enable_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (wr_en && (paddr == `TSR_OFF_CTRL)) |=> (s_q.enable == $past(pwdata[`TSR_CTRL_ENABLE])))
    else $error("enable bit not written");

  mask_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (wr_en && (paddr == `TSR_OFF_MASK)) |=> (s_q.mask == $past(pwdata[2:0])))
    else $error("mask register not written");

  state_ro_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (wr_en && (paddr == `TSR_OFF_STATE) && !tgt_cmd && !ctl_cmd) |=>
      ((s_q.target == $past(s_q.target)) && (s_q.armed == $past(s_q.armed))))
    else $error("write to state register changed state");

  apb_error_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (psel && penable && !pready && !addr_mapped(paddr)) |=>
      (pready && pslverr && (prdata == 32'h0000_0000)))
    else $error("unmapped access not refused");

  apb_okay_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (psel && penable && !pready && addr_mapped(paddr)) |=> (pready && !pslverr))
    else $error("mapped access answered with error");

  pready_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pready |=> !pready)
    else $error("APB ready held longer than one cycle");

  state_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (psel && penable && !pready && !pwrite && (paddr == `TSR_OFF_STATE)) |=>
      (prdata[6:0] == $past(present_sec)))
    else $error("state read does not show present sector");

  status_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (psel && penable && !pready && !pwrite && (paddr == `TSR_OFF_STATUS)) |=>
      (prdata[2:0] == $past(s_q.status)))
    else $error("status read does not show status bits");

  int_armed_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rps_int |-> $past(s_q.armed))
    else $error("interrupt raised while sensing disarmed");

  int_repeat_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(rps_int) |-> s_q.status[`TSR_EV_MATCH])
    else $error("match interrupt not recorded in status");

endmodule : tsr_top

/* tsr_top_dummy_guard.sv */
// Empty compilation unit; the block's logic lives in the other design files
`timescale 1ns/1ps

/* tsr_top_test.sv */
// Self-checking bench for the target sector block
`timescale 1ns/1ps
`include "tsr_cfg.svh"
module tsr_top_test;
  typedef struct {logic [2:0] code; logic [7:0] ob; logic [7:0] exp;} tsr_row_s;
  logic        sys_clk, sys_rst, tag_gate, sector_mark, index_mark, rps_int;
  logic        psel, penable, pwrite, pready, pslverr, irq, er;
  logic [2:0]  tag_code;
  logic [7:0]  outbound_bus_bit, inbound_bus_bit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_errors = 0;
  int          checked = 0;
  tsr_row_s    rows [6];

  tsr_ctrl_model tsr_ctrl_model_i (.sys_clk(sys_clk), .tag_gate(tag_gate), .tag_code(tag_code),
    .outbound_bus_bit(outbound_bus_bit), .sector_mark(sector_mark), .index_mark(index_mark));
  tsr_top tsr_top_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .tag_gate(tag_gate), .tag_code(tag_code),
    .outbound_bus_bit(outbound_bus_bit), .sector_mark(sector_mark), .index_mark(index_mark),
    .inbound_bus_bit(inbound_bus_bit), .rps_int(rps_int), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .irq(irq));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Bit 1 carries weight 64, bit 7 weight 1
  function automatic logic [7:0] sec_byte(input logic [6:0] s, input logic arm);
    sec_byte[0] = arm;
    for (int i = 1; i < 8; i++) sec_byte[i] = s[7-i];
  endfunction : sec_byte

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (n >= 50) chk(32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wrap_up();
    $display("Checks %0d, errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    wrap_up();
  end

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rows[0] = '{3'h5, sec_byte(7'h45, 1'b1), sec_byte(7'h45, 1'b1)};
    rows[1] = '{3'h5, sec_byte(7'h12, 1'b0), sec_byte(7'h03, 1'b0)};
    rows[2] = '{3'h7, 8'h01, sec_byte(7'h03, 1'b1)};
    rows[3] = '{3'h7, 8'h00, sec_byte(7'h03, 1'b1)};
    rows[4] = '{3'h3, 8'h0B, sec_byte(7'h03, 1'b1)};
    rows[5] = '{3'h5, 8'hFF, 8'hFF};
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    chk(inbound_bus_bit, 32'h0);
    chk({rps_int, irq}, 32'h0);
    apb(1'b0, `TSR_OFF_CTRL, 32'h0);
    chk(rd, 32'h1);
    $display("reset test done");
    repeat (3) tsr_ctrl_model_i.mark(1'b0);
    foreach (rows[i]) begin
      tsr_ctrl_model_i.send_tag(rows[i].code, rows[i].ob, 1 + i % 2);
      chk(inbound_bus_bit, rows[i].exp);
      $display("row %0d done", i);
    end
    apb(1'b0, `TSR_OFF_STATE, 32'h0);
    chk(rd, 32'h00017F03);
    apb(1'b0, `TSR_OFF_STATUS, 32'h0);
    chk(rd, 32'h7);
    apb(1'b1, `TSR_OFF_STATUS, 32'h7);
    // Two revolutions: the match must come back on each
    tsr_ctrl_model_i.send_tag(3'h5, sec_byte(7'h02, 1'b1), 1);
    repeat (2) begin
      tsr_ctrl_model_i.mark(1'b1);
      repeat (2) tsr_ctrl_model_i.mark(1'b0);
      repeat (2) @(posedge sys_clk);
      chk(rps_int, 32'h1);
    end
    apb(1'b1, `TSR_OFF_MASK, 32'h1);
    @(posedge sys_clk);
    chk(irq, 32'h1);
    apb(1'b1, `TSR_OFF_STATUS, 32'h1);
    @(posedge sys_clk);
    chk(irq, 32'h0);
    tsr_ctrl_model_i.mark(1'b0);
    repeat (2) @(posedge sys_clk);
    chk(rps_int, 32'h0);
    $display("match test done");
    tsr_ctrl_model_i.send_tag(3'h5, 8'h00, 1);
    chk(inbound_bus_bit, sec_byte(7'h03, 1'b0));
    tsr_ctrl_model_i.mark(1'b1);
    repeat (3) tsr_ctrl_model_i.mark(1'b0);
    repeat (2) @(posedge sys_clk);
    chk(rps_int, 32'h0);
    $display("capture test done");
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, `TSR_OFF_CTRL, 32'h0);
    chk({31'h0, er}, 32'h0);
    tsr_ctrl_model_i.send_tag(3'h5, sec_byte(7'h10, 1'b1), 1);
    chk(inbound_bus_bit, sec_byte(7'h03, 1'b0));
    apb(1'b1, `TSR_OFF_CTRL, 32'h1);
    tsr_ctrl_model_i.send_tag(3'h5, 8'h81, 1);
    chk(inbound_bus_bit, 8'h81);
    apb(1'b1, `TSR_OFF_CTRL, 32'h3);
    @(posedge sys_clk);
    chk(inbound_bus_bit, 8'h80);
    apb(1'b1, `TSR_OFF_STATE, 32'hFFFF_FFFF);
    apb(1'b0, `TSR_OFF_STATE, 32'h0);
    chk(rd, 32'h0000_0103);
    apb(1'b1, `TSR_OFF_MASK, 32'h4);
    tsr_ctrl_model_i.send_tag(3'h7, 8'h01, 1);
    chk(irq, 32'h1);
    $display("bus test done");
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    chk(inbound_bus_bit, 32'h0);
    chk({rps_int, irq}, 32'h0);
    apb(1'b0, `TSR_OFF_STATE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `TSR_OFF_MASK, 32'h0);
    chk(rd, 32'h0);
    $display("second reset test done");
    wrap_up();
  end
endmodule : tsr_top_test
